// ==== dcs_consts.vh ====
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
`define DCS_ADDR_CMD 4'h0
`define DCS_ADDR_SEL 4'h4
`define DCS_ADDR_STAT 4'h8
`define DCS_RESP_OK 2'b00
`define DCS_RESP_SLVERR 2'b10
`define DCS_CMD_ARM 8'h80
`define DCS_CMD_DISABLE 8'h01
`define DCS_CMD_ENABLE 8'h02
`define DCS_CMD_REQUEST 8'h03
`define DCS_CMD_SWITCH 8'h04
`define DCS_CMD_RECOVER 8'h05
`define DCS_CMD_WDARL 8'h06
`define DCS_F_SOURCE_SELECT_FIELD 3:0
`define DCS_F_STARTUP_TIME_FIELD 5:4
`define DCS_F_CLOCK_OUT_BIT 6
`define DCS_F_ARM 7
`define DCS_F_RDY 4
`define DCS_FUSE_CLOCK_OUT_FUSE 6
`define DCS_FUSE_RSTDIS 8
`define DCS_SEL_RESET 7'h00
`define DCS_S_RC 3'h0
`define DCS_S_WD 3'h1
`define DCS_S_EXT 3'h2
`define DCS_S_LF 3'h3
`define DCS_S_XT 3'h4
`define DCS_S_NONE 3'h7
`define DCS_SOURCE_SELECT_FIELD_EXT 4'h0
`define DCS_SOURCE_SELECT_FIELD_RC 4'h2
`define DCS_SOURCE_SELECT_FIELD_WD 4'h3
`define DCS_SOURCE_SELECT_FIELD_LF 4'h4
`define DCS_SOURCE_SELECT_FIELD_XT 4'h8
`define DCS_SUT_00 2'b00
`define DCS_SUT_01 2'b01
`define DCS_SUT_10 2'b10
`define DCS_LIM_EXT 16'h0006
`define DCS_LIM_INT 16'h0006
`define DCS_LIM_258 16'h0102
`define DCS_LIM_1K 16'h0400
`define DCS_LIM_16K 16'h4000
`define DCS_LIM_32K 16'h8000
`define DCS_BOOT_CK 21'h00000e
`define DCS_WAKE_CK 3'h6
`define DCS_FUSE_WAIT 2'h3
`define DCS_CLK_MHZ 20
`define DCS_T_4_US 4000
`define DCS_T_4P1_US 4100
`define DCS_T_65_US 65000
`endif

// ==== dcs_ready_cnt.v ====
`timescale 1ns/1ps
module dcs_ready_cnt (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire [15:0] limit,
  input wire tick,
  output reg ready_q,
  output reg busy_q
);
  reg [15:0] cnt_q;
  reg [15:0] lim_q;
  wire [15:0] cnt_inc = cnt_q + 16'h0001;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      lim_q <= 16'h0000;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (start) begin
      // flag drops as counting starts
      cnt_q <= 16'h0000;
      lim_q <= limit;
      ready_q <= 1'b0;
      busy_q <= 1'b1;
    end else if (busy_q && tick) begin
      cnt_q <= cnt_inc;
      if (cnt_inc == lim_q) begin
        busy_q <= 1'b0;
        ready_q <= 1'b1;
      end
    end
  end
endmodule // dcs_ready_cnt

// ==== dcs_sync.v ====
`timescale 1ns/1ps
module dcs_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // dcs_sync

// ==== dcs_top.v ====
// How it works
// [R01] external clock wakes from power-down after six source cycles
// [R02] reset delay after 14 cycles follows startup code for external clock
// [R03] async timer may enable external input only with no crystal running
// [R04] clock-out bit and no crystal: system clock drives pin, not in reset
// [R05] clock pin carries prescaled system clock when prescaler divides
// [R06] command register changes only via the protected write procedure
// [R07] software writes change-enable alone, then the command code
// [R08] exclusive command decode launches one operation at a time
// [R09] select register loads from low fuse byte at reset
// [R10] enable turns on selected source with selected startup time
// [R11] disable turns off selected source unless it drives system clock or is the pending switch target
// [R12] several sources may stay enabled together
// [R13] availability count clears ready at start, sets at limit, holds
// [R14] enable command launches readiness count automatically
// [R15] software keeps fields still while counting, waits for ready
// [R16] recover writes active source code into source field only
// [R17] switch can pick RC, watchdog, external, low-freq or crystal
// [R18] software checks ready, switches, recovers, then disables old
// [R19] software should mask interrupts around the switch sequence
// [R20] sources switch glitch-free via park-low handover
// [R21] command write not directly after change-enable is ignored
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_top #(
  parameter integer P_MS4_CYC = `DCS_T_4_US * `DCS_CLK_MHZ,
  parameter integer P_MS4P1_CYC = `DCS_T_4P1_US * `DCS_CLK_MHZ,
  parameter integer P_MS65_CYC = `DCS_T_65_US * `DCS_CLK_MHZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] osc_in,
  input wire [7:0] low_fuse_byte,
  input wire reset_pin_disable_fuse,
  input wire async_timer_ext_req,
  input wire [3:0] prescale_sel,
  input wire wake_req,
  output reg [4:0] src_enable_q,
  output reg [4:0] sysclk_sel_q,
  output reg sysclk_out_pin,
  output reg sysclk_out_oe_n,
  output reg cpu_run_q,
  output reg wake_done_q,
  output reg wd_autoreload_q
);
  localparam [3:0] B_LOAD = 4'b0001;
  localparam [3:0] B_CK = 4'b0010;
  localparam [3:0] B_MS = 4'b0100;
  localparam [3:0] B_RUN = 4'b1000;
  localparam [2:0] SW_IDLE = 3'b001;
  localparam [2:0] SW_OFF = 3'b010;
  localparam [2:0] SW_ON = 3'b100;

  function [2:0] src_of;
    input [3:0] source_select_field;
    begin
      if (source_select_field[3])
        src_of = `DCS_S_XT;
      else if (source_select_field[3:2] == `DCS_SOURCE_SELECT_FIELD_LF >> 2)
        src_of = `DCS_S_LF;
      else if (source_select_field == `DCS_SOURCE_SELECT_FIELD_EXT)
        src_of = `DCS_S_EXT;
      else if (source_select_field == `DCS_SOURCE_SELECT_FIELD_RC)
        src_of = `DCS_S_RC;
      else if (source_select_field == `DCS_SOURCE_SELECT_FIELD_WD)
        src_of = `DCS_S_WD;
      else
        src_of = `DCS_S_NONE;
    end
  endfunction

  function [3:0] code_of;
    input [2:0] s;
    begin
      case (s)
        `DCS_S_WD: code_of = `DCS_SOURCE_SELECT_FIELD_WD;
        `DCS_S_EXT: code_of = `DCS_SOURCE_SELECT_FIELD_EXT;
        `DCS_S_LF: code_of = `DCS_SOURCE_SELECT_FIELD_LF;
        `DCS_S_XT: code_of = `DCS_SOURCE_SELECT_FIELD_XT;
        default: code_of = `DCS_SOURCE_SELECT_FIELD_RC;
      endcase
    end
  endfunction

  function [4:0] onehot;
    input [2:0] s;
    begin
      onehot = (s > `DCS_S_XT) ? 5'h00 : (5'h01 << s);
    end
  endfunction

  function pick;
    input [4:0] v;
    input [2:0] s;
    begin
      pick = |(v & onehot(s));
    end
  endfunction

  // readiness limit per source and startup field
  function [15:0] limit_of;
    input [2:0] s;
    input [1:0] sut;
    begin
      case (s)
        `DCS_S_EXT: limit_of = `DCS_LIM_EXT;
        `DCS_S_LF: limit_of = (sut == `DCS_SUT_10) ? `DCS_LIM_32K
                                                   : `DCS_LIM_1K;
        `DCS_S_XT: limit_of = (sut == `DCS_SUT_00) ? `DCS_LIM_258
                                                   : `DCS_LIM_16K;
        default: limit_of = `DCS_LIM_INT;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire [4:0] osc_s;
  wire [8:0] fuse_s;
  reg [4:0] osc_d1_q;
  wire [4:0] osc_rise = osc_s & ~osc_d1_q;
  wire [4:0] osc_fall = ~osc_s & osc_d1_q;
  wire [31:0] ms4_w = P_MS4_CYC;
  wire [31:0] ms41_w = P_MS4P1_CYC;
  wire [31:0] ms65_w = P_MS65_CYC;

  dcs_sync #(.W(5)) u_osc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(osc_in),
    .dout(osc_s)
  );

  dcs_sync #(.W(9)) u_fuse_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({reset_pin_disable_fuse, low_fuse_byte}),
    .dout(fuse_s)
  );

  reg [6:0] sel_q;
  reg [4:0] en_q;
  reg [2:0] act_q;
  reg [2:0] tgt_q;
  reg [2:0] cnt_src_q;
  reg [3:0] boot_q;
  reg [2:0] sw_q;
  reg [1:0] fw_q;
  reg [20:0] bcnt_q;
  reg arm_q;
  reg [2:0] wk_cnt_q;
  reg wk_busy_q;
  reg [8:0] div_q;
  reg aw_held_q;
  reg w_held_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;
  wire rdy;
  wire cnt_busy;

  wire [2:0] sel_src = src_of(sel_q[`DCS_F_SOURCE_SELECT_FIELD]);
  wire do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
  wire cmd_wr = do_wr && wstrb0_q && (awaddr_q == `DCS_ADDR_CMD);
  wire [7:0] cmd = wdata_q[7:0];
  // any other value directly after the arm write fires a command
  wire cmd_go = cmd_wr && arm_q && (cmd != `DCS_CMD_ARM); // see [R06] [R21]
  wire cnt_start = cmd_go && (sel_src != `DCS_S_NONE) &&
    ((cmd == `DCS_CMD_ENABLE) || (cmd == `DCS_CMD_REQUEST)); // see [R14]
  wire act_lvl = pick(osc_s, act_q);
  wire [9:0] div_sh = {div_q, act_lvl} >> prescale_sel;

  dcs_ready_cnt u_ready (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cnt_start),
    .limit(limit_of(sel_src, sel_q[`DCS_F_STARTUP_TIME_FIELD])),
    .tick(pick(osc_rise, cnt_src_q)),
    .ready_q(rdy),
    .busy_q(cnt_busy)
  ); // see [R13]

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCS_RESP_OK;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DCS_RESP_OK;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `DCS_ADDR_CMD ||
          awaddr_q == `DCS_ADDR_SEL) ? `DCS_RESP_OK : `DCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DCS_RESP_OK;
        case (s_axi_araddr)
          `DCS_ADDR_CMD: s_axi_rdata <= {24'h000000, arm_q, 2'b00, rdy,
                                         4'h0};
          `DCS_ADDR_SEL: s_axi_rdata <= {25'h0000000, sel_q};
          `DCS_ADDR_STAT: s_axi_rdata <= {19'h00000, src_enable_q, 2'b00,
                                          sw_q != SW_IDLE, cnt_busy,
                                          cpu_run_q, act_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot, registers and command execution
  always @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= B_LOAD;
      fw_q <= 2'h0;
      bcnt_q <= 21'h000000;
      sel_q <= `DCS_SEL_RESET;
      en_q <= 5'h00;
      act_q <= `DCS_S_RC;
      tgt_q <= `DCS_S_RC;
      cnt_src_q <= `DCS_S_RC;
      sw_q <= SW_IDLE;
      sysclk_sel_q <= 5'h00;
      arm_q <= 1'b0;
      cpu_run_q <= 1'b0;
      wd_autoreload_q <= 1'b0;
    end else begin
      // any write ends the armed window
      if (do_wr)
        arm_q <= cmd_wr && (cmd == `DCS_CMD_ARM); // see [R07] [R21]
      if (do_wr && wstrb0_q && awaddr_q == `DCS_ADDR_SEL)
        sel_q <= wdata_q[6:0];
      case (boot_q)
        B_LOAD: begin
          // fuses settle through the synchroniser first
          fw_q <= fw_q + 2'h1;
          if (fw_q == `DCS_FUSE_WAIT) begin
            sel_q <= {~fuse_s[`DCS_FUSE_CLOCK_OUT_FUSE], fuse_s[5:0]}; // see [R09]
            act_q <= (src_of(fuse_s[3:0]) == `DCS_S_NONE) ? `DCS_S_RC
                     : src_of(fuse_s[3:0]);
            en_q <= onehot((src_of(fuse_s[3:0]) == `DCS_S_NONE) ?
                           `DCS_S_RC : src_of(fuse_s[3:0]));
            bcnt_q <= 21'h000000;
            boot_q <= B_CK;
          end
        end
        B_CK: begin
          if (~|sysclk_sel_q && sw_q == SW_IDLE && pick(src_enable_q, act_q))
            sysclk_sel_q <= onehot(act_q); // see [R20]
          if (pick(osc_rise, act_q))
            bcnt_q <= bcnt_q + 21'h000001;
          if (bcnt_q == `DCS_BOOT_CK) begin
            boot_q <= B_RUN;
            if (act_q == `DCS_S_EXT) begin // see [R02]
              case (sel_q[`DCS_F_STARTUP_TIME_FIELD])
                `DCS_SUT_00: bcnt_q <= fuse_s[`DCS_FUSE_RSTDIS] ?
                                       ms4_w[20:0] : 21'h000000;
                `DCS_SUT_01: bcnt_q <= ms41_w[20:0];
                `DCS_SUT_10: bcnt_q <= ms65_w[20:0];
                default: bcnt_q <= 21'h000000;
              endcase
              boot_q <= B_MS;
            end else begin
              cpu_run_q <= 1'b1;
            end
          end
        end
        B_MS: begin
          if (bcnt_q == 21'h000000) begin
            boot_q <= B_RUN;
            cpu_run_q <= 1'b1;
          end else begin
            bcnt_q <= bcnt_q - 21'h000001;
          end
        end
        B_RUN: cpu_run_q <= 1'b1;
        default: boot_q <= B_LOAD;
      endcase
      if (cnt_start)
        cnt_src_q <= sel_src;
      if (cmd_go) begin
        case (cmd) // see [R08]
          `DCS_CMD_DISABLE:
            if (sel_src != act_q && !(sw_q != SW_IDLE && sel_src == tgt_q))
              en_q <= en_q & ~onehot(sel_src); // see [R11]
          `DCS_CMD_ENABLE:
            en_q <= en_q | onehot(sel_src); // see [R10] [R12]
          `DCS_CMD_SWITCH:
            if (sw_q == SW_IDLE && sel_src != `DCS_S_NONE &&
                sel_src != act_q && pick(en_q, sel_src)) begin
              tgt_q <= sel_src; // see [R17]
              sw_q <= SW_OFF;
            end
          `DCS_CMD_RECOVER:
            sel_q[`DCS_F_SOURCE_SELECT_FIELD] <= code_of(act_q); // see [R16]
          `DCS_CMD_WDARL:
            wd_autoreload_q <= 1'b1;
          default: ;
        endcase
      end
      // park the tree low on the old source's fall, then hand over on
      // the new source's fall so neither leaves a runt pulse
      case (sw_q)
        SW_IDLE: ;
        SW_OFF:
          if (pick(osc_fall, act_q)) begin
            sysclk_sel_q <= 5'h00; // see [R20]
            sw_q <= SW_ON;
          end
        SW_ON:
          if (pick(osc_fall, tgt_q)) begin
            sysclk_sel_q <= onehot(tgt_q); // see [R20]
            act_q <= tgt_q;
            sw_q <= SW_IDLE;
          end
        default: sw_q <= SW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source enables, wake-up and clock output
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_d1_q <= 5'h00;
      src_enable_q <= 5'h00;
      wk_busy_q <= 1'b0;
      wk_cnt_q <= 3'h0;
      wake_done_q <= 1'b0;
      div_q <= 9'h000;
      sysclk_out_pin <= 1'b0;
      sysclk_out_oe_n <= 1'b1;
    end else begin
      osc_d1_q <= osc_s;
      src_enable_q <= en_q | ((async_timer_ext_req &&
        !en_q[`DCS_S_XT] && !en_q[`DCS_S_LF]) ? onehot(`DCS_S_EXT)
        : 5'h00); // see [R03]
      wake_done_q <= 1'b0;
      if (wake_req && !wk_busy_q && cpu_run_q) begin
        wk_busy_q <= (act_q == `DCS_S_EXT);
        wake_done_q <= (act_q != `DCS_S_EXT);
        wk_cnt_q <= 3'h0;
      end else if (wk_busy_q && pick(osc_rise, act_q)) begin
        wk_cnt_q <= wk_cnt_q + 3'h1;
        if (wk_cnt_q + 3'h1 == `DCS_WAKE_CK) begin
          wk_busy_q <= 1'b0;
          wake_done_q <= 1'b1; // see [R01]
        end
      end
      if (pick(osc_rise, act_q))
        div_q <= div_q + 9'h001;
      // pin is a resampled copy, so sources above aclk/2 alias
      sysclk_out_pin <= div_sh[0]; // see [R05]
      sysclk_out_oe_n <= !(sel_q[`DCS_F_CLOCK_OUT_BIT] && cpu_run_q &&
        !en_q[`DCS_S_XT] && !en_q[`DCS_S_LF] &&
        sysclk_sel_q != 5'h00); // see [R04]
    end
  end
endmodule // dcs_top

// ==== dcs_top_assertions.sv ====
`timescale 1ns/1ps
module dcs_chk (
  input wire aclk,
  input wire aresetn,
  input wire async_timer_ext_req,
  input wire [4:0] src_enable_q,
  input wire [4:0] sysclk_sel_q,
  input wire sysclk_out_oe_n,
  input wire cpu_run_q,
  input wire wake_done_q,
  input wire wd_autoreload_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // outputs still show reset values at the first edge after release
  pin_quiet_a: assert property (
    $rose(aresetn) |-> sysclk_out_oe_n)
    else $error("clock pin driven straight out of reset");
  boot_wait_a: assert property (
    $rose(aresetn) |-> (!cpu_run_q)[*8])
    else $error("boot delay too short");
  run_hold_a: assert property (
    cpu_run_q |=> cpu_run_q)
    else $error("run flag dropped");
  pin_run_a: assert property (
    !sysclk_out_oe_n |-> cpu_run_q)
    else $error("clock pin driven before boot done");
  mux_onehot_a: assert property (
    $onehot0(sysclk_sel_q))
    else $error("system clock mux not one-hot");
  // handover must pass through the parked state
  park_low_a: assert property ($changed(sysclk_sel_q) &&
    sysclk_sel_q != 5'h00 |-> $past(sysclk_sel_q) == 5'h00)
    else $error("clock mux switched without parking");
  active_on_a: assert property (
    (sysclk_sel_q & ~src_enable_q) == 5'h00)
    else $error("active source disabled");
  wake_pulse_a: assert property (
    wake_done_q |=> !wake_done_q)
    else $error("wake done longer than one cycle");
  wd_sticky_a: assert property (
    wd_autoreload_q |=> wd_autoreload_q)
    else $error("auto reload cleared");
  timer_ext_a: assert property (async_timer_ext_req &&
    !src_enable_q[3] && !src_enable_q[4] |-> ##[1:3] src_enable_q[2])
    else $error("timer request did not enable external input");
endmodule // dcs_chk
////////////////////////////////////////////////////////////
bind dcs_top dcs_chk i_chk (
  .aclk, .aresetn, .async_timer_ext_req, .src_enable_q, .sysclk_sel_q,
  .sysclk_out_oe_n, .cpu_run_q, .wake_done_q, .wd_autoreload_q
);

// ==== dcs_top_tb.sv ====
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [4:0] osc_in = 5'h00;
  logic [7:0] low_fuse_byte = 8'h02;
  logic reset_pin_disable_fuse = 1'b0;
  logic async_timer_ext_req = 1'b0;
  logic [3:0] prescale_sel = 4'h0;
  logic wake_req = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] src_enable_q, sysclk_sel_q;
  wire sysclk_out_pin, sysclk_out_oe_n, cpu_run_q, wake_done_q, wd_autoreload_q;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int ocnt [5];
  integer seed = 32'h83c2ab00;
  logic [31:0] rdat;
  logic [1:0] resp;

  dcs_top #(.P_MS4_CYC(20), .P_MS4P1_CYC(21), .P_MS65_CYC(40)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .osc_in, .low_fuse_byte, .reset_pin_disable_fuse, .async_timer_ext_req,
    .prescale_sel, .wake_req, .src_enable_q, .sysclk_sel_q, .sysclk_out_pin,
    .sysclk_out_oe_n, .cpu_run_q, .wake_done_q, .wd_autoreload_q
  );
  always #25 aclk = ~aclk;
  // source i toggles every i+2 cycles, so all stay below aclk/2
  always @(posedge aclk) begin
    for (int i = 0; i < 5; i++) begin
      if (ocnt[i] == i + 1) begin
        ocnt[i] <= 0;
        osc_in[i] <= ~osc_in[i];
      end else begin
        ocnt[i] <= ocnt[i] + 1;
      end
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_sel(input logic [7:0] f);
    return {25'h0, ~f[6], f[5:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the leading edge keeps bready/rready from being set twice in a step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(`DCS_ADDR_CMD, {24'h0, `DCS_CMD_ARM});
    wr(`DCS_ADDR_CMD, {24'h0, c});
  endtask
  // rises of the clock pin over a fixed window of aclk cycles
  task automatic pin_rises(output int r);
    logic p;
    r = 0;
    repeat (8) @(posedge aclk);
    p = sysclk_out_pin;
    repeat (256) begin
      @(posedge aclk);
      if (sysclk_out_pin && !p) r++;
      p = sysclk_out_pin;
    end
  endtask
  task automatic wake(output int n);
    @(posedge aclk);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (wake_done_q !== 1'b1 && n < 300);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [31:0] v;
    logic [7:0] c;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (cpu_run_q !== 1'b1 && n < 500);
    chk(n >= 50 && n <= 80, 32'h1);
    rd(`DCS_ADDR_SEL);
    chk(rdat, exp_sel(low_fuse_byte));
    rd(`DCS_ADDR_STAT);
    chk(rdat[2:0], `DCS_S_RC);
    chk(src_enable_q, 5'h01);
    chk(sysclk_out_oe_n, 1'b0);
    $display("test boot done");
    async_timer_ext_req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(src_enable_q, 5'h05);
    async_timer_ext_req <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(src_enable_q, 5'h01);
    $display("test timer done");
    wr(`DCS_ADDR_SEL, 32'h0);
    wr(`DCS_ADDR_CMD, {24'h0, `DCS_CMD_ENABLE});
    @(posedge aclk);
    chk(src_enable_q, 5'h01);
    wr(`DCS_ADDR_CMD, {24'h0, `DCS_CMD_ARM});
    wr(`DCS_ADDR_SEL, 32'h0);
    wr(`DCS_ADDR_CMD, {24'h0, `DCS_CMD_ENABLE});
    @(posedge aclk);
    chk(src_enable_q, 5'h01);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      c = {1'b0, v[6:0]};
      if (c < 8'h07) c = c + 8'h07;
      prescale_sel <= v[11:8] % 4'ha;
      cmd(c);
      @(posedge aclk);
      chk(src_enable_q, 5'h01);
      wr(4'hc, v);
      chk(resp, `DCS_RESP_SLVERR);
      rd(4'hc);
      chk({rdat, resp}, {32'h0, `DCS_RESP_SLVERR});
    end
    $display("test protect done");
    cmd(`DCS_CMD_ENABLE);
    rd(`DCS_ADDR_CMD);
    chk(rdat[`DCS_F_RDY], 1'b0);
    n = 0;
    do begin
      rd(`DCS_ADDR_CMD);
      n++;
    end while (rdat[`DCS_F_RDY] !== 1'b1 && n < 60);
    chk(rdat[`DCS_F_RDY], 1'b1);
    chk(src_enable_q, 5'h05);
    // a fresh request must drop the flag that is already set
    cmd(`DCS_CMD_REQUEST);
    rd(`DCS_ADDR_CMD);
    chk(rdat[`DCS_F_RDY], 1'b0);
    n = 0;
    do begin
      rd(`DCS_ADDR_CMD);
      n++;
    end while (rdat[`DCS_F_RDY] !== 1'b1 && n < 60);
    chk(rdat[`DCS_F_RDY], 1'b1);
    wr(`DCS_ADDR_SEL, 32'h02);
    cmd(`DCS_CMD_DISABLE);
    @(posedge aclk);
    chk(src_enable_q, 5'h05);
    wake(n);
    chk(n <= 2, 32'h1);
    $display("test enable done");
    wr(`DCS_ADDR_SEL, 32'h0);
    // the bench raises no interrupts, so none need masking
    cmd(`DCS_CMD_SWITCH);
    n = 0;
    do begin
      cmd(`DCS_CMD_RECOVER);
      rd(`DCS_ADDR_SEL);
      n++;
    end while (rdat[3:0] !== `DCS_SOURCE_SELECT_FIELD_EXT && n < 40);
    chk(sysclk_sel_q, 5'h04);
    rd(`DCS_ADDR_STAT);
    chk(rdat[2:0], `DCS_S_EXT);
    wr(`DCS_ADDR_SEL, 32'h5f);
    cmd(`DCS_CMD_RECOVER);
    rd(`DCS_ADDR_SEL);
    chk(rdat, 32'h50);
    wr(`DCS_ADDR_SEL, 32'h02);
    cmd(`DCS_CMD_DISABLE);
    @(posedge aclk);
    chk(src_enable_q, 5'h04);
    wake(n);
    chk(n >= 40 && n <= 64, 32'h1);
    cmd(`DCS_CMD_WDARL);
    chk(wd_autoreload_q, 1'b1);
    $display("test switch done");
    // external source rises every 8 cycles: 32 rises undivided, 16 halved
    prescale_sel <= 4'h0;
    pin_rises(n);
    chk(n >= 31 && n <= 33, 32'h1);
    prescale_sel <= 4'h1;
    pin_rises(n);
    chk(n >= 15 && n <= 17, 32'h1);
    $display("test pin done");
    results();
  end
endmodule // dcs_top_tb
